// ---- core/sjtp_pkg.sv ----
// Package of constants and types for the serial test access port.
// Assumes nothing of its surroundings; used by every file under core/.
package sjtp_pkg;

    // Sixteen controller states, one-hot.
    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAP_DR  = 16'h0008,
        ST_SHF_DR  = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAU_DR  = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAP_IR  = 16'h0400,
        ST_SHF_IR  = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAU_IR  = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } sjtp_state_e;

    localparam int IR_W = 3;
    localparam int ID_W = 32;

    // Instruction codes.
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // Pattern captured into the two low instruction bits.
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    // Identification code; value is arbitrary.
    localparam logic [ID_W-1:0] ID_CODE = 32'h0000_0001;

    // Pin levels, raw or synchronised.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sjtp_pins_s;

endpackage

// ---- core/sjtp_sync.sv ----
// Two-flop synchroniser for the three serial test inputs.
// Assumes pins are asynchronous to mclk; undriven pins pulled high outside.
`timescale 1ns/100ps
module sjtp_sync (
    input  wire logic              mclk,
    input  wire logic              nrst,
    input  wire logic              cen,
    input  wire sjtp_pkg::sjtp_pins_s pin_in,
    output sjtp_pkg::sjtp_pins_s      pin_out
);

    sjtp_pkg::sjtp_pins_s meta_reg;
    sjtp_pkg::sjtp_pins_s sync_reg;

    // Both stages reset high, matching an idle floating pin.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else if (cen) begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_out = sync_reg;

endmodule

// ---- core/sjtp_tap.sv ----
// Serial test access port: controller, instruction, bypass and id paths.
// Assumes tck, tms and tdi come from pins; tdo wire resolved by the bench.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
module sjtp_tap (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic cen,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    output logic      tdo_out,
    output logic      tdo_oe_n,
    output logic      test_active
);

    sjtp_pkg::sjtp_pins_s      pin_raw;
    sjtp_pkg::sjtp_pins_s      pin_s;
    logic                      tck_d_reg;
    sjtp_pkg::sjtp_state_e     state_reg;
    sjtp_pkg::sjtp_state_e     state_next;
    logic [sjtp_pkg::IR_W-1:0] ir_sh_reg;
    logic [sjtp_pkg::IR_W-1:0] ir_reg;
    logic [sjtp_pkg::ID_W-1:0] id_reg;
    logic                      byp_reg;
    logic                      tdo_reg;
    logic                      oe_n_reg;
    logic                      act_reg;

    assign pin_raw = '{tck: tck, tms: tms, tdi: tdi};

    // Pins pass two flops before use.
    sjtp_sync u_sync (
        .mclk    (mclk),
        .nrst    (nrst),
        .cen     (cen),
        .pin_in  (pin_raw),
        .pin_out (pin_s)
    );

    // Edge detection on the synchronised test clock.
    wire tck_rise = pin_s.tck & ~tck_d_reg;
    wire tck_fall = ~pin_s.tck & tck_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Controller next state from the sampled mode input.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sjtp_pkg::ST_RESET:
                state_next = pin_s.tms ? sjtp_pkg::ST_RESET
                                       : sjtp_pkg::ST_IDLE;
            sjtp_pkg::ST_IDLE:
                state_next = pin_s.tms ? sjtp_pkg::ST_SEL_DR
                                       : sjtp_pkg::ST_IDLE;
            sjtp_pkg::ST_SEL_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_SEL_IR
                                       : sjtp_pkg::ST_CAP_DR;
            sjtp_pkg::ST_CAP_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX1_DR
                                       : sjtp_pkg::ST_SHF_DR;
            sjtp_pkg::ST_SHF_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX1_DR
                                       : sjtp_pkg::ST_SHF_DR;
            sjtp_pkg::ST_EX1_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_UPD_DR
                                       : sjtp_pkg::ST_PAU_DR;
            sjtp_pkg::ST_PAU_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX2_DR
                                       : sjtp_pkg::ST_PAU_DR;
            sjtp_pkg::ST_EX2_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_UPD_DR
                                       : sjtp_pkg::ST_SHF_DR;
            sjtp_pkg::ST_UPD_DR:
                state_next = pin_s.tms ? sjtp_pkg::ST_SEL_DR
                                       : sjtp_pkg::ST_IDLE;
            sjtp_pkg::ST_SEL_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_RESET
                                       : sjtp_pkg::ST_CAP_IR;
            sjtp_pkg::ST_CAP_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX1_IR
                                       : sjtp_pkg::ST_SHF_IR;
            sjtp_pkg::ST_SHF_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX1_IR
                                       : sjtp_pkg::ST_SHF_IR;
            sjtp_pkg::ST_EX1_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_UPD_IR
                                       : sjtp_pkg::ST_PAU_IR;
            sjtp_pkg::ST_PAU_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_EX2_IR
                                       : sjtp_pkg::ST_PAU_IR;
            sjtp_pkg::ST_EX2_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_UPD_IR
                                       : sjtp_pkg::ST_SHF_IR;
            sjtp_pkg::ST_UPD_IR:
                state_next = pin_s.tms ? sjtp_pkg::ST_SEL_DR
                                       : sjtp_pkg::ST_IDLE;
            default:
                state_next = sjtp_pkg::ST_RESET;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // One-hot state test shared by every state decode below.
    function automatic logic is_state(input sjtp_pkg::sjtp_state_e cur,
                                      input sjtp_pkg::sjtp_state_e want);
        return (cur == want);
    endfunction

    // State decode and output selection.
    wire in_shf_dr = is_state(state_reg, sjtp_pkg::ST_SHF_DR);
    wire in_shf_ir = is_state(state_reg, sjtp_pkg::ST_SHF_IR);
    wire in_cap_dr = is_state(state_reg, sjtp_pkg::ST_CAP_DR);
    wire in_cap_ir = is_state(state_reg, sjtp_pkg::ST_CAP_IR);
    wire in_upd_ir = is_state(state_reg, sjtp_pkg::ST_UPD_IR);
    wire in_reset  = is_state(state_reg, sjtp_pkg::ST_RESET);
    wire sel_id    = (ir_reg == sjtp_pkg::INS_IDCODE);
    wire shifting  = in_shf_dr | in_shf_ir;
    // Instruction path in Shift-IR, else id or bypass by instruction.
    wire tdo_sel   = in_shf_ir ? ir_sh_reg[0]
                   : (sel_id ? id_reg[0] : byp_reg);

    // Register strobes: capture and shift on a rise, output on a fall.
    wire rise_en   = cen & tck_rise;
    wire fall_en   = cen & tck_fall;
    wire ir_cap    = rise_en & in_cap_ir;
    wire ir_shf    = rise_en & in_shf_ir;
    wire ir_upd    = rise_en & in_upd_ir;
    wire id_cap    = rise_en & in_cap_dr & sel_id;
    wire id_shf    = rise_en & in_shf_dr & sel_id;
    wire byp_cap   = rise_en & in_cap_dr;
    wire byp_shf   = rise_en & in_shf_dr;

    // Controller steps only on a rising test clock edge.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tck_d_reg <= 1'b1;
            state_reg <= sjtp_pkg::ST_RESET;
        end else if (cen) begin
            tck_d_reg <= pin_s.tck;
            if (tck_rise) begin
                state_reg <= state_next;
            end
        end
    end

    // Instruction shift and update registers; Test-Logic-Reset holds the
    // default instruction at once, without waiting for another rise.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ir_sh_reg <= sjtp_pkg::INS_IDCODE;
            ir_reg    <= sjtp_pkg::INS_IDCODE;
        end else if (cen) begin
            if (in_reset) begin
                ir_reg <= sjtp_pkg::INS_IDCODE;
            end else if (ir_upd) begin
                ir_reg <= ir_sh_reg;
            end
            if (ir_cap) begin
                ir_sh_reg <= {ir_sh_reg[sjtp_pkg::IR_W-1:2],
                              sjtp_pkg::IR_CAPTURE};
            end else if (ir_shf) begin
                ir_sh_reg <= {pin_s.tdi,
                              ir_sh_reg[sjtp_pkg::IR_W-1:1]};
            end
        end
    end

    // Data registers: id captures its code, bypass captures zero.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            id_reg  <= sjtp_pkg::ID_CODE;
            byp_reg <= 1'b0;
        end else begin
            if (id_cap) begin
                id_reg <= sjtp_pkg::ID_CODE;
            end else if (id_shf) begin
                id_reg <= {pin_s.tdi,
                           id_reg[sjtp_pkg::ID_W-1:1]};
            end
            if (byp_cap) begin
                byp_reg <= 1'b0;
            end else if (byp_shf) begin
                byp_reg <= pin_s.tdi;
            end
        end
    end

    // Output pin changes only on a falling test clock edge.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tdo_reg  <= 1'b1;
            oe_n_reg <= 1'b1;
            act_reg  <= 1'b0;
        end else if (fall_en) begin
            tdo_reg  <= tdo_sel;
            oe_n_reg <= ~shifting;
            act_reg  <= ~in_reset;
        end
    end

    // Every output comes straight from its flop.
    assign tdo_out     = tdo_reg;
    assign tdo_oe_n    = oe_n_reg;
    assign test_active = act_reg;

endmodule

// ---- dv/sjtp_tap_monitor.sv ----
// Concurrent checks on the test port outputs.
// Assumes tck half periods of eight mclk cycles.
`timescale 1ns/100ps
module sjtp_tap_monitor (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cen,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_out,
    input wire logic tdo_oe_n,
    input wire logic test_active
);
    logic       tck_reg;
    logic       seen_reg;
    logic [2:0] ones_reg;
    wire        rise = tck & ~tck_reg;
    wire        fall = ~tck & tck_reg;
    ////////////////////////////////////////
    // Tracks tck edges and the run of tms highs at rises.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            tck_reg  <= 1'b0;
            seen_reg <= 1'b0;
            ones_reg <= 3'h0;
        end else begin
            tck_reg  <= tck;
            seen_reg <= seen_reg | rise | fall;
            if (rise)
                ones_reg <= !tms ? 3'h0 : (ones_reg == 3'h5) ? 3'h5
                          : ones_reg + 3'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_quiet; $stable(tdo_out) [*8]; endsequence
    sequence s_off; !test_active && tdo_oe_n; endsequence
    sequence s_held;
        $stable(tdo_out) && $stable(tdo_oe_n) && $stable(test_active);
    endsequence
    property p_rst; $rose(nrst) |-> s_off; endproperty
    property p_tdo; $changed(tdo_out) |-> !tck; endproperty
    property p_oe; $changed(tdo_oe_n) |-> !tck; endproperty
    property p_hold; $changed(tdo_out) |=> s_quiet; endproperty
    property p_five; ones_reg == 3'h5 && fall |-> ##[1:6] s_off; endproperty
    property p_hiz; !test_active |-> tdo_oe_n; endproperty
    property p_idle; !seen_reg |-> s_off; endproperty
    property p_ta; $changed(test_active) |-> !tck; endproperty
    property p_frz; !cen |=> s_held; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_tdo: assert property (p_tdo) else $error("tdo moved, tck high");
    a_oe: assert property (p_oe) else $error("oe moved, tck high");
    a_hold: assert property (p_hold) else $error("tdo not held");
    a_five: assert property (p_five) else $error("no reset on tms");
    a_hiz: assert property (p_hiz) else $error("tdo driven in reset");
    a_idle: assert property (p_idle) else $error("active unclocked");
    a_ta: assert property (p_ta) else $error("state moved, tck high");
    a_frz: assert property (p_frz) else $error("frozen output moved");
endmodule
bind sjtp_tap sjtp_tap_monitor mon (.mclk(mclk), .nrst(nrst), .cen(cen),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_out(tdo_out),
    .tdo_oe_n(tdo_oe_n), .test_active(test_active));

// ---- dv/sjtp_host_bfm.sv ----
// Behavioural scan controller driving tck, tms and tdi.
// Assumes a 10 ns mclk; tck runs only inside step calls.
`timescale 1ns/100ps
module sjtp_host_bfm (
    input  wire logic mclk,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    ////////////////////////////////////////
    // Clock stands low between frames; data lines start high, then keep the last step's values.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 160 ns tck period; data set at the fall, held through the rise.
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        repeat (8) @(negedge mclk);
        tck = 1'b1;
        repeat (8) @(negedge mclk);
        tck = 1'b0;
    endtask
    // Five highs on tms bring the port back to its reset state.
    task automatic reset5;
        repeat (5) step(1'b1, 1'b1);
    endtask
endmodule

// ---- dv/sjtp_tap_tb_top.sv ----
// Self-checking bench for the test access port.
// Assumes the host model drives pins; tdo is resolved here.
`timescale 1ns/100ps
module sjtp_tap_tb_top;
    logic        mclk;
    logic        nrst;
    logic        cen;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo_out;
    logic        tdo_oe_n;
    logic        test_active;
    logic        chk;
    logic [2:0]  ir;
    logic [63:0] din;
    logic        q[$];
    int          fails = 0;
    int          check_count = 0;
    int          cycles = 0;
    int          seed = 17174;
    wire         tdo = tdo_oe_n ? 1'bz : tdo_out;
    ////////////////////////////////////////
    // System clock of 100 MHz.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    sjtp_tap i_sjtp_tap (.mclk(mclk), .nrst(nrst), .cen(cen), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n),
        .test_active(test_active));
    sjtp_host_bfm host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi));
    task automatic check_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Cuts a hang short.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            finish_test();
        end
    end
    // Takes the oldest note whenever chk is set and tdo is driven at a tck rise.
    always @(posedge tck) begin
        if (chk && tdo_oe_n === 1'b0) begin
            if (q.size() == 0) check_bit("oe", 1'b1, 1'b0);
            else check_bit("tdo", q.pop_front(), tdo);
        end
    end
    task automatic seq(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) host.step(b[i], 1'b1);
    endtask
    task automatic scan(input logic [63:0] d, e, input int n);
        for (int i = 0; i < n; i++) begin
            q.push_back(e[i]);
            host.step(i == n - 1, d[i]);
        end
    endtask
    task automatic load_ir(input logic [2:0] c);
        seq(8'h03, 4);
        scan({61'h0, c}, {61'h0, ir[2], sjtp_pkg::IR_CAPTURE}, 3);
        seq(8'h01, 2);
        ir = c;
    endtask
    task automatic read_dr(input int n);
        din = {$random(seed), $random(seed)};
        seq(8'h01, 3);
        if (ir == sjtp_pkg::INS_IDCODE)
            scan(din, {din[31:0], sjtp_pkg::ID_CODE}, n);
        else scan(din, {din[62:0], 1'b0}, n);
        seq(8'h01, 2);
    endtask
    // Main sequence.
    initial begin
        nrst = 1'b0;
        cen = 1'b1;
        chk = 1'b0;
        ir = sjtp_pkg::INS_IDCODE;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        check_bit("active", 1'b0, test_active);
        chk = 1'b1;
        seq(8'h00, 1);
        read_dr(40);
        // A test clock pulse made while the clock enable is low is ignored.
        cen = 1'b0;
        host.step(1'b1, 1'b1);
        cen = 1'b1;
        read_dr(34);
        for (int c = 0; c < 8; c++) begin
            load_ir(c[2:0]);
            read_dr(34);
        end
        // A mid-run hardware reset brings back the default instruction.
        nrst = 1'b0;
        repeat (10) @(negedge mclk);
        nrst = 1'b1;
        repeat (4) @(negedge mclk);
        check_bit("active", 1'b0, test_active);
        check_bit("oe", 1'b1, tdo_oe_n);
        ir = sjtp_pkg::INS_IDCODE;
        seq(8'h00, 1);
        read_dr(40);
        chk = 1'b0;
        repeat (40) begin
            din = {$random(seed), $random(seed)};
            host.step(din[0], din[1]);
        end
        host.reset5();
        repeat (8) @(negedge mclk);
        check_bit("active", 1'b0, test_active);
        check_bit("oe", 1'b1, tdo_oe_n);
        ir = sjtp_pkg::INS_IDCODE;
        chk = 1'b1;
        seq(8'h00, 1);
        read_dr(40);
        repeat (20) @(negedge mclk);
        check_bit("left", 1'b1, q.size() == 0);
        finish_test();
    end
endmodule
